// >>> verilog/rps_pin_select.sv
// Remappable pin select crossbar with Avalon-MM register slave
module rps_pin_select
   import rps_pkg::*;
#(
   parameter bit HAS_CAN = 1'b1,
   parameter bit PINS_44 = 1'b1
)
(
   input wire logic clock,
   input wire logic arst_n,
   input wire rps_bus_req_s busReq,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [RPS_PIN_COUNT-1:0] remappablePinIn,
   output logic spi2SlaveSelectIn,
   output logic canReceiveIn,
   input wire logic [RPS_FUNC_COUNT-1:0] periphOut,
   input wire logic [RPS_PIN_COUNT-1:0] portOut,
   output logic [RPS_PIN_COUNT-1:0] remappablePinOut,
   output logic [RPS_PIN_COUNT-1:0] pinRemapped
);
   localparam int OUT_REGS_LIVE = PINS_44 ? RPS_OUT_REGS : 8;

   logic [4:0] spi2SelectSource;
   logic [4:0] canReceiveSource;
   logic [4:0] pinFunctionCode [RPS_PIN_COUNT];
   logic ackPending;

   wire logic access = busReq.read | busReq.write;
   wire logic [3:0] wordIdx = busReq.address[5:2];
   wire logic hitSpi = busReq.address == RPS_OFS_SPI2_SEL;
   wire logic hitCan = (busReq.address == RPS_OFS_CAN_SEL) && HAS_CAN;
   wire logic [3:0] outIdx = 4'(wordIdx - 4'(RPS_OFS_OUT_MAP0 >> 2));
   wire logic hitOut = (busReq.address[1:0] == 2'b00) && (wordIdx >= 4'd2)
      && (outIdx < 4'(OUT_REGS_LIVE));
   // Write lands at the edge where waitrequest is seen low
   wire logic doWrite = busReq.write && ackPending;
   wire logic [4:0] wrEven = busReq.writedata[RPS_EVEN_LSB +: RPS_SEL_W];
   wire logic [4:0] wrOdd = busReq.writedata[RPS_ODD_LSB +: RPS_SEL_W];

   wire logic [31:0] rdSpi = {27'h0, spi2SelectSource};
   wire logic [31:0] rdCan = {27'h0, canReceiveSource};
   wire logic [31:0] rdOut = hitOut ?
      {19'h0, pinFunctionCode[{outIdx, 1'b1}], 3'h0, pinFunctionCode[{outIdx, 1'b0}]} : 32'h0;
   wire logic [31:0] next_readdata = hitSpi ? rdSpi : hitCan ? rdCan : rdOut;

   // One wait cycle, then acknowledge
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ackPending <= 1'b0;
         waitrequest <= 1'b1;
         readdata <= 32'h0;
      end
      else
      begin
         ackPending <= access && !ackPending;
         waitrequest <= !(access && !ackPending);
         readdata <= (busReq.read && !ackPending) ? next_readdata : 32'h0;
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         spi2SelectSource <= RPS_IN_SEL_RST;
         canReceiveSource <= RPS_IN_SEL_RST;
      end
      else
      begin
         if (doWrite && hitSpi)
            spi2SelectSource <= wrEven;
         if (doWrite && hitCan)
            canReceiveSource <= wrEven;
      end
   end

   function automatic logic pickPin(input logic [4:0] sel, input logic [25:0] pins);
      logic v;
      v = 1'b0;
      if (sel < 5'(RPS_PIN_COUNT))
         v = pins[sel];
      return v;
   endfunction : pickPin

   wire logic next_spi2 = pickPin(spi2SelectSource, remappablePinIn);
   wire logic next_can = HAS_CAN ? pickPin(canReceiveSource, remappablePinIn) : 1'b0;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         spi2SlaveSelectIn <= 1'b0;
         canReceiveIn <= 1'b0;
      end
      else
      begin
         spi2SlaveSelectIn <= next_spi2;
         canReceiveIn <= next_can;
      end
   end

   genvar p;
   generate
      for (p = 0; p < RPS_PIN_COUNT; p++)
      begin : g_pin
         localparam logic [3:0] REG_IDX = 4'(p / 2);
         wire logic [4:0] wrField = (p % 2 == 0) ? wrEven : wrOdd;
         wire logic wrHit = doWrite && hitOut && (outIdx == REG_IDX);
         wire logic [4:0] code = pinFunctionCode[p];
         wire logic remapped = code != RPS_FUNC_NONE;
         wire logic next_pin = remapped ? periphOut[code] : portOut[p];

         always_ff @(posedge clock or negedge arst_n)
         begin
            if (!arst_n)
            begin
               pinFunctionCode[p] <= RPS_OUT_SEL_RST;
               remappablePinOut[p] <= 1'b0;
               pinRemapped[p] <= 1'b0;
            end
            else
            begin
               if (wrHit)
                  pinFunctionCode[p] <= wrField;
               remappablePinOut[p] <= next_pin;
               pinRemapped[p] <= remapped;
            end
         end
      end
   endgenerate

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   AST_SPI_ROUTE: assert property (
      spi2SelectSource < 5'd26 |=> spi2SlaveSelectIn == $past(remappablePinIn[spi2SelectSource]))
      else $error("spi2 input not routed from selected pin");
   AST_SPI_LOW: assert property (
      spi2SelectSource == RPS_SEL_TIED_LOW |=> !spi2SlaveSelectIn)
      else $error("spi2 input not tied low");
   AST_SPI_WRITE: assert property (
      doWrite && hitSpi |=> spi2SelectSource == $past(wrEven))
      else $error("spi2 selector write lost");
   AST_CAN_WRITE: assert property (
      doWrite && hitCan |=> canReceiveSource == $past(wrEven))
      else $error("can selector write lost");
   AST_CAN_OFF: assert property (
      !HAS_CAN |-> !canReceiveIn)
      else $error("can input active without controller");
   AST_RD_SINGLE: assert property (
      busReq.read && !ackPending && hitSpi |=> readdata[31:5] == 27'h0 && !waitrequest)
      else $error("single-field readback upper bits set");
   AST_RD_DOUBLE: assert property (
      !waitrequest |-> readdata[15:13] == 3'h0 && readdata[7:5] == 3'h0)
      else $error("two-field readback reserved bits set");
   AST_PIN_NONE: assert property (
      pinFunctionCode[0] == RPS_FUNC_NONE |=> remappablePinOut[0] == $past(portOut[0]))
      else $error("unmapped pin not driven by port");
   AST_ACK_ONE: assert property (
      access && waitrequest |-> ##[0:1] !waitrequest)
      else $error("bus answer late");
   AST_PIN_MAP: assert property (
      pinFunctionCode[1] != 5'h0 |=> remappablePinOut[1] == $past(periphOut[pinFunctionCode[1]]))
      else $error("odd pin not driven by selected function");

   COV_SPI_WR: cover property (doWrite && hitSpi);
   COV_OUT_WR: cover property (doWrite && hitOut);
   COV_READ: cover property (busReq.read && !waitrequest);
endmodule : rps_pin_select

// >>> verilog/rps_pkg.sv
// Package for the remappable pin select crossbar
package rps_pkg;
   localparam int RPS_PIN_COUNT = 26;
   localparam int RPS_SEL_W = 5;
   localparam int RPS_OUT_REGS = 13;
   localparam int RPS_FUNC_COUNT = 32;
   localparam int RPS_ADDR_W = 6;
   // Byte offsets
   localparam logic [5:0] RPS_OFS_SPI2_SEL = 6'h00;
   localparam logic [5:0] RPS_OFS_CAN_SEL = 6'h04;
   localparam logic [5:0] RPS_OFS_OUT_MAP0 = 6'h08;
   // Field positions
   localparam int RPS_EVEN_LSB = 0;
   localparam int RPS_ODD_LSB = 8;
   // Reset values, tied-low and no-function codes
   localparam logic [4:0] RPS_IN_SEL_RST = 5'h1f;
   localparam logic [4:0] RPS_OUT_SEL_RST = 5'h00;
   localparam logic [4:0] RPS_SEL_TIED_LOW = 5'h1f;
   localparam logic [4:0] RPS_FUNC_NONE = 5'h00;

   typedef struct packed {
      logic read;
      logic write;
      logic [RPS_ADDR_W-1:0] address;
      logic [31:0] writedata;
   } rps_bus_req_s;
endpackage : rps_pkg

// >>> tb/rps_far_side.sv
// Pin levels and peripheral outputs around the crossbar
module rps_far_side
   import rps_pkg::*;
(
   input wire logic lvl,
   output logic [RPS_PIN_COUNT-1:0] pins,
   output logic [RPS_FUNC_COUNT-1:0] periph,
   output logic [RPS_PIN_COUNT-1:0] portLvl
);
   timeunit 1ns;
   timeprecision 1ns;
   assign pins = lvl ? 26'h2aaaaaa : 26'h1555555;
   assign periph = lvl ? 32'hcccccccc : 32'h33333333;
   assign portLvl = ~pins;
endmodule : rps_far_side

// >>> tb/testbench.sv
// Self-checking bench for the pin select crossbar
module testbench
   import rps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic lvl = 1'b0;
   rps_bus_req_s req = '0;
   logic [31:0] readdata;
   logic [31:0] q;
   logic [31:0] periph;
   logic waitrequest;
   logic spiIn;
   logic canIn;
   logic [25:0] pins;
   logic [25:0] portLvl;
   logic [25:0] pinOut;
   logic [25:0] pinMapped;
   int failCount = 0;
   int nCompared = 0;
   rps_pin_select i_rps_pin_select (.clock(clock), .arst_n(arst_n), .busReq(req),
      .readdata(readdata), .waitrequest(waitrequest), .remappablePinIn(pins),
      .spi2SlaveSelectIn(spiIn), .canReceiveIn(canIn), .periphOut(periph),
      .portOut(portLvl), .remappablePinOut(pinOut), .pinRemapped(pinMapped));
   rps_far_side i_rps_far_side (.lvl(lvl), .pins(pins), .periph(periph), .portLvl(portLvl));
   always #10 clock = ~clock;
   task automatic close_out();
      $display("compared %0d mismatches %0d", nCompared, failCount);
      if (failCount == 0 && nCompared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      nCompared++;
      if (got !== exp)
      begin
         failCount++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic xfer(input bit w, input logic [5:0] a, input logic [31:0] d,
      output logic [31:0] r);
      int t = 0;
      @(posedge clock);
      req <= '{read: !w, write: w, address: a, writedata: d};
      do
      begin
         @(posedge clock);
         t++;
      end
      while (waitrequest !== 1'b0 && t < 50);
      if (t >= 50)
         failCount++;
      r = readdata;
      req <= '0;
   endtask : xfer
   task automatic settle(input bit l);
      @(posedge clock);
      lvl <= l;
      repeat (3) @(posedge clock);
      @(negedge clock);
   endtask : settle
   task automatic check_reset();
      settle(1'b0);
      cmp({6'h0, pinMapped}, 32'h0);
      cmp({6'h0, pinOut}, {6'h0, portLvl});
      xfer(1'b0, RPS_OFS_SPI2_SEL, '0, q);
      cmp(q, 32'h1f);
      xfer(1'b0, RPS_OFS_CAN_SEL, '0, q);
      cmp(q, 32'h1f);
      for (int k = 0; k < 13; k++)
      begin
         xfer(1'b0, RPS_OFS_OUT_MAP0 + 6'(4 * k), '0, q);
         cmp(q, 32'h0);
      end
   endtask : check_reset
   task automatic route_in(input logic [5:0] a, input bit can);
      for (int n = 0; n < 32; n++)
      begin
         xfer(1'b1, a, 32'hffffffe0 | n, q);
         xfer(1'b0, a, '0, q);
         cmp(q, 32'(n));
         for (int l = 0; l < 2; l++)
         begin
            settle(l[0]);
            cmp({31'h0, can ? canIn : spiIn}, {31'h0, n < 26 ? pins[n % 26] : 1'b0});
         end
      end
   endtask : route_in
   task automatic route_out();
      for (int k = 0; k < 13; k++)
      begin
         xfer(1'b1, RPS_OFS_OUT_MAP0 + 6'(4 * k), 32'hffffe0e0 | (k * 2 + 2) << 8 | (k * 2 + 1), q);
         xfer(1'b0, RPS_OFS_OUT_MAP0 + 6'(4 * k), '0, q);
         cmp(q, (k * 2 + 2) << 8 | (k * 2 + 1));
      end
      for (int l = 0; l < 2; l++)
      begin
         settle(l[0]);
         cmp({6'h0, pinOut}, {6'h0, periph[26:1]});
         cmp({6'h0, pinMapped}, 32'h03ffffff);
      end
      xfer(1'b1, RPS_OFS_OUT_MAP0, '0, q);
      settle(1'b1);
      cmp({30'h0, pinOut[1:0]}, {30'h0, portLvl[1:0]});
      cmp({30'h0, pinMapped[1:0]}, 32'h0);
   endtask : route_out
   initial
   begin
      repeat (8) @(posedge clock);
      arst_n <= 1'b1;
      check_reset();
      route_in(RPS_OFS_SPI2_SEL, 1'b0);
      route_in(RPS_OFS_CAN_SEL, 1'b1);
      route_out();
      xfer(1'b1, 6'h3c, 32'hffffffff, q);
      xfer(1'b0, 6'h3c, '0, q);
      cmp(q, 32'h0);
      xfer(1'b0, 6'h01, '0, q);
      cmp(q, 32'h0);
      close_out();
   end
   initial
   begin
      repeat (20000) @(posedge clock);
      failCount++;
      close_out();
   end
endmodule : testbench
